//--- rx_test_config_and_reset_tb.sv
// Purpose: Bench joining host and receiver ends through the link
// Assumes: Shortened waits; APB master drives the host
// Notes: Register values from a fixed seed plus corner table
`timescale 1ns/100ps
`include "rxtc_defines.svh"
module rx_test_config_and_reset_tb import rxtc_pkg::*;;
	localparam logic [19:0] POR_W = 20'h007D0;
	localparam logic [19:0] PULSE_W = 20'h00014;
	localparam logic [19:0] MWAIT_W = 20'h007D0;
	logic mclk, rst, psel, penable, pwrite, afc_en, aux_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, chip_ready, high_sens_mode, ext_ref_select;
	logic [7:0] lna_gain_select, fading_margin_setting, narrow_index_freq_offset, v, b;
	logic [1:0] synth_loop_bw;
	logic [9:0] synth_bw_khz;
	logic [16:0] freq_offset_hz;
	rxtc_fade_t fading_mode;
	logic [7:0] model [5];
	logic [6:0] adrs [5];
	logic [2:0] ci [13] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
		3'h3, 3'h4, 3'h3};
	logic [7:0] cv [13] = '{8'h2D, 8'h1B, 8'h10, 8'h09, 8'h00, 8'h04, 8'h08, 8'h0C,
		8'h00, 8'h20, 8'h30, 8'hFF, 8'h55};
	int n_fail = 0, check_count = 0, cyc = 0, t0, i;

	rxtc_link_if u_rxtc_link_if ();
	rxtc_host #(.POR_WAIT_CYC(POR_W), .MRST_PULSE_CYC(PULSE_W), .MRST_WAIT_CYC(MWAIT_W))
	u_rxtc_host (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(u_rxtc_link_if.host));
	rxtc_device #(.BOOT_CYC(16'h0032)) u_rxtc_device (.mclk(mclk), .rst(rst),
		.link(u_rxtc_link_if.device), .narrow_index_afc_enable(afc_en),
		.lna_gain_select(lna_gain_select), .high_sens_mode(high_sens_mode),
		.ext_ref_select(ext_ref_select), .synth_loop_bw(synth_loop_bw),
		.synth_bw_khz(synth_bw_khz), .fading_margin_setting(fading_margin_setting),
		.fading_mode(fading_mode), .narrow_index_freq_offset(narrow_index_freq_offset),
		.freq_offset_hz(freq_offset_hz), .chip_ready(chip_ready));
	rxtc_link_monitor #(.POR_WAIT_CYC(int'(POR_W)), .MRST_PULSE_CYC(int'(PULSE_W)),
		.MRST_WAIT_CYC(int'(MWAIT_W))) u_mon (.mclk(mclk), .rst(rst),
		.sck(u_rxtc_link_if.sck), .cs_n(u_rxtc_link_if.cs_n),
		.miso_oe_n(u_rxtc_link_if.miso_oe_n), .rst_pin_oe_n(u_rxtc_link_if.rst_pin_oe_n),
		.rst_pin(u_rxtc_link_if.rst_pin), .aux_clock_out(u_rxtc_link_if.aux_clock_out));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic give_up;
		n_fail++;
		test_done();
	endtask : give_up
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) give_up();
		r = prdata;
		chk(pslverr, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One SPI frame through the host registers
	task automatic dev(input logic wr, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] r);
		logic [31:0] s;
		int n;
		apb(1'b1, `RXTC_APB_XFER, {17'h00000, a, d}, s);
		apb(1'b1, `RXTC_APB_CTRL, {28'h0000000, aux_mode, 1'b0, wr, 1'b1}, s);
		n = 0;
		do begin
			apb(1'b0, `RXTC_APB_STAT, 32'h00000000, s);
			n++;
		end while (s[0] !== 1'b0 && n < 200);
		if (n >= 200) give_up();
		r = s[15:8];
		repeat (4) @(posedge mclk);
	endtask : dev
	task automatic wait_ready;
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			apb(1'b0, `RXTC_APB_STAT, 32'h00000000, s);
			n++;
		end while (s[1] !== 1'b1 && n < 3000);
		if (n >= 3000) give_up();
	endtask : wait_ready

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic logic [9:0] bw_khz(input logic [1:0] c);
		case (c)
			2'h0: return `RXTC_BW0_KHZ;
			2'h1: return `RXTC_BW1_KHZ;
			2'h2: return `RXTC_BW2_KHZ;
			default: return `RXTC_BW3_KHZ;
		endcase
	endfunction : bw_khz
	function automatic rxtc_fade_t fade_of(input logic [7:0] f);
		if (f == `RXTC_FADE_NORMAL) return RXTC_FADE_NORMAL;
		if (f == `RXTC_FADE_AFC_ON) return RXTC_FADE_AFC_ON;
		if (f == `RXTC_FADE_AFC_OFF) return RXTC_FADE_AFC_OFF;
		return RXTC_FADE_OTHER;
	endfunction : fade_of
	task automatic chk_outs;
		chk(lna_gain_select, model[0]);
		chk(high_sens_mode, model[0] == `RXTC_LNA_HIGH);
		chk(ext_ref_select, model[1][`RXTC_EXT_REF_BIT]);
		chk(synth_loop_bw, model[2][3:2]);
		chk(synth_bw_khz, bw_khz(model[2][3:2]));
		chk(fading_margin_setting, model[3]);
		chk(fading_mode, fade_of(model[3]));
		chk(narrow_index_freq_offset, model[4]);
		chk(freq_offset_hz, afc_en ? 17'(model[4] * `RXTC_OFS_STEP_HZ) : 17'h0);
	endtask : chk_outs
	task automatic reset_check;
		model = '{`RXTC_RST_LNA, `RXTC_RST_REFOSC, `RXTC_RST_SYNTHBW, `RXTC_RST_FADING,
			`RXTC_RST_OFFSET};
		foreach (adrs[k]) begin
			dev(1'b0, adrs[k], 8'h00, b);
			chk(b, model[k]);
		end
		chk_outs();
	endtask : reset_check
	// Manual reset; counts cycles with the pin high
	task automatic mrst(input logic [31:0] ctl);
		int n;
		apb(1'b1, `RXTC_APB_CTRL, ctl, q);
		n = 0;
		for (int c = 0; c < 200; c++) begin
			@(posedge mclk);
			if (u_rxtc_link_if.rst_pin === 1'b1) n++;
			else if (n > 0) break;
		end
		chk(n, PULSE_W);
		chk(chip_ready, 1'b0);
		t0 = cyc;
		wait_ready();
		chk(chip_ready, 1'b1);
	endtask : mrst

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		afc_en = 1'b0;
		aux_mode = 1'b0;
		adrs = '{`RXTC_ADR_LNA, `RXTC_ADR_REFOSC, `RXTC_ADR_SYNTHBW, `RXTC_ADR_FADING,
			`RXTC_ADR_OFFSET};
		void'($urandom(32'h15A1569C));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t0 = cyc;
		repeat (5) @(posedge mclk);
		chk(chip_ready, 1'b0);
		repeat (60) @(posedge mclk);
		chk(chip_ready, 1'b1);
		wait_ready();
		chk(cyc - t0 >= int'(POR_W), 1'b1);
		reset_check();
		apb(1'b1, 12'h00C, 32'hFFFFFFFF, q);
		apb(1'b0, 12'h00C, 32'h00000000, q);
		chk(q, 32'h00000000);
		for (int k = 0; k < 28; k++) begin
			i = (k < 13) ? ci[k] : $urandom_range(4, 0);
			v = (k < 13) ? cv[k] : 8'($urandom);
			afc_en <= k[0];
			dev(1'b1, adrs[i], v, b);
			model[i] = v;
			dev(1'b0, adrs[i], 8'h00, b);
			chk(b, v);
			chk_outs();
		end
		mrst(32'h00000004);
		chk(cyc - t0 >= int'(MWAIT_W), 1'b1);
		reset_check();
		apb(1'b1, `RXTC_APB_CTRL, 32'h00000008, q);
		aux_mode = 1'b1;
		mrst(32'h0000000C);
		chk(cyc - t0 < int'(MWAIT_W), 1'b1);
		apb(1'b0, `RXTC_APB_CTRL, 32'h00000000, q);
		chk(q[3], 1'b1);
		reset_check();
		test_done();
	end
endmodule : rx_test_config_and_reset_tb

//--- rxtc_defines.svh
// Purpose: Shared constants of the receiver tuning bank and its host
// Assumes: 100 MHz mclk on both ends
// Notes: Definitions only
`ifndef RXTC_DEFINES_SVH
`define RXTC_DEFINES_SVH

// ----------------------------------------
// Device register addresses and resets
// ----------------------------------------
`define RXTC_ADR_LNA 7'h58
`define RXTC_ADR_REFOSC 7'h59
`define RXTC_ADR_SYNTHBW 7'h5F
`define RXTC_ADR_FADING 7'h6F
`define RXTC_ADR_OFFSET 7'h71
`define RXTC_RST_LNA 8'h1B
`define RXTC_LNA_HIGH 8'h2D
`define RXTC_RST_REFOSC 8'h09
`define RXTC_RST_SYNTHBW 8'h08
`define RXTC_RST_FADING 8'h30
`define RXTC_RST_OFFSET 8'h00
`define RXTC_FADE_NORMAL 8'h00
`define RXTC_FADE_AFC_ON 8'h20
`define RXTC_FADE_AFC_OFF 8'h30
`define RXTC_EXT_REF_BIT 4
`define RXTC_BW_MSB 3
`define RXTC_BW_LSB 2
`define RXTC_BW0_KHZ 10'h04B
`define RXTC_BW1_KHZ 10'h096
`define RXTC_BW2_KHZ 10'h12C
`define RXTC_BW3_KHZ 10'h258
`define RXTC_OFS_STEP_HZ 17'h001E8

// ----------------------------------------
// Timing
// ----------------------------------------
`define RXTC_CLK_HZ 100000000
`define RXTC_POR_WAIT_MS 10
`define RXTC_POR_WAIT_CYC (`RXTC_POR_WAIT_MS * (`RXTC_CLK_HZ / 1000))
`define RXTC_MRST_PULSE_US 100
`define RXTC_MRST_PULSE_CYC (`RXTC_MRST_PULSE_US * (`RXTC_CLK_HZ / 1000000))
`define RXTC_MRST_WAIT_MS 5
`define RXTC_MRST_WAIT_CYC (`RXTC_MRST_WAIT_MS * (`RXTC_CLK_HZ / 1000))
`define RXTC_BOOT_CYC 1000
`define RXTC_SCK_HALF 3'h7
`define RXTC_AUX_HALF 2'h3
`define RXTC_SPI_LAST 4'hF
`define RXTC_ADDR_LAST 4'h7

// ----------------------------------------
// Host APB register map and fields
// ----------------------------------------
`define RXTC_APB_CTRL 12'h000
`define RXTC_APB_XFER 12'h004
`define RXTC_APB_STAT 12'h008
`define RXTC_CTRL_GO 0
`define RXTC_CTRL_WR 1
`define RXTC_CTRL_MRST 2
`define RXTC_CTRL_AUXRDY 3
`endif

//--- rxtc_device.sv
// Purpose: Receiver tuning register bank with reset sequencing
// Assumes: Host keeps the waits after power-on and manual reset
// Notes: rst stands for supply coming up; reset pin is the manual path
//
// Overview of operation
// - Sensitivity register resets 0x1B; 0x2D selects high.
// - Bit 4 selects external reference over crystal.
// - Fading margin register: 0x00, 0x20, 0x30 settings.
// - Offset times 488 Hz applied while AFC enabled.
// - Power-on sequence starts by itself at supply.
// - Host waits 10 ms after power-on before SPI.
// - Host leaves reset pin floating during power-on.
// - Host drives reset pin high about 100 us.
// - Host waits 5 ms after releasing reset pin.
// - Aux clock activity may signal readiness instead.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`include "rxtc_defines.svh"
module rxtc_device import rxtc_pkg::*; #(
	parameter logic [15:0] BOOT_CYC = 16'(`RXTC_BOOT_CYC)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Link to host
	rxtc_link_if.device link,
	// Receiver status in
	input wire logic narrow_index_afc_enable,
	// Tuning outputs
	output logic [7:0] lna_gain_select,
	output logic high_sens_mode,
	output logic ext_ref_select,
	output logic [1:0] synth_loop_bw,
	output logic [9:0] synth_bw_khz,
	output logic [7:0] fading_margin_setting,
	output rxtc_fade_t fading_mode,
	output logic [7:0] narrow_index_freq_offset,
	output logic [16:0] freq_offset_hz,
	// Sequencer status
	output logic chip_ready
);
	logic pin_s1_reg, pin_s2_reg;
	rxtc_dstate_t state_reg;
	logic [15:0] boot_cnt_reg;
	logic [1:0] aux_cnt_reg;
	logic aux_reg;
	logic [7:0] lna_reg, refosc_reg, synthbw_reg, fading_reg, offset_reg;
	logic [6:0] spi_addr;
	logic [7:0] spi_wdata, spi_rdata;
	logic spi_wr, spi_rst, regs_rst;
	// Outputs during reset show the bank's own reset fields
	localparam logic [7:0] RST_BW = `RXTC_RST_SYNTHBW;
	localparam logic [7:0] RST_REF = `RXTC_RST_REFOSC;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [9:0] bw_khz(input logic [1:0] code);
		case (code)
			2'b00: bw_khz = `RXTC_BW0_KHZ;
			2'b01: bw_khz = `RXTC_BW1_KHZ;
			2'b10: bw_khz = `RXTC_BW2_KHZ;
			default: bw_khz = `RXTC_BW3_KHZ;
		endcase
	endfunction : bw_khz

	function automatic rxtc_fade_t fade_decode(input logic [7:0] v);
		case (v)
			`RXTC_FADE_NORMAL: fade_decode = RXTC_FADE_NORMAL;
			`RXTC_FADE_AFC_ON: fade_decode = RXTC_FADE_AFC_ON;
			`RXTC_FADE_AFC_OFF: fade_decode = RXTC_FADE_AFC_OFF;
			default: fade_decode = RXTC_FADE_OTHER;
		endcase
	endfunction : fade_decode

	// ----------------------------------------
	// Reset sequencing
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		pin_s1_reg <= link.rst_pin;
		pin_s2_reg <= pin_s1_reg;
	end

	// Supply-up needs no host action; manual pin holds then reboots
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= RXTC_D_BOOT;
			boot_cnt_reg <= 16'h0000;
		end else if (pin_s2_reg) begin
			state_reg <= RXTC_D_HOLD;
			boot_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				RXTC_D_HOLD: begin
					state_reg <= RXTC_D_BOOT;
				end
				RXTC_D_BOOT: begin
					boot_cnt_reg <= boot_cnt_reg + 16'h0001;
					if (boot_cnt_reg == BOOT_CYC - 16'h0001) begin
						state_reg <= RXTC_D_READY;
					end
				end
				RXTC_D_READY: begin
					state_reg <= RXTC_D_READY;
				end
				default: begin
					state_reg <= RXTC_D_BOOT;
				end
			endcase
		end
	end

	assign chip_ready = (state_reg == RXTC_D_READY);

	// Aux clock runs only once ready, so its activity marks readiness
	always_ff @(posedge mclk) begin
		if (rst || !chip_ready) begin
			aux_cnt_reg <= 2'b00;
			aux_reg <= 1'b0;
		end else begin
			aux_cnt_reg <= aux_cnt_reg + 2'b01;
			if (aux_cnt_reg == `RXTC_AUX_HALF) begin
				aux_reg <= !aux_reg;
			end
		end
	end

	assign link.aux_clock_out = aux_reg;

	// ----------------------------------------
	// SPI access
	// ----------------------------------------
	// Frames are ignored until the boot sequence completes
	assign spi_rst = rst || !chip_ready;

	rxtc_spi_slave u_spi (
		.mclk(mclk),
		.rst(spi_rst),
		.sck_pin(link.sck),
		.cs_n_pin(link.cs_n),
		.mosi_pin(link.mosi),
		.miso_o(link.miso_o),
		.miso_oe_n(link.miso_oe_n),
		.rdata(spi_rdata),
		.addr(spi_addr),
		.wdata(spi_wdata),
		.wr_pulse(spi_wr)
	);

	// ----------------------------------------
	// Register bank
	// ----------------------------------------
	// Manual pin resets the bank as power-on does
	assign regs_rst = rst || pin_s2_reg;

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			lna_reg <= `RXTC_RST_LNA;
		end else if (spi_wr && spi_addr == `RXTC_ADR_LNA) begin
			lna_reg <= spi_wdata;
		end
	end

	// Reserved bits are kept as written
	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			refosc_reg <= `RXTC_RST_REFOSC;
		end else if (spi_wr && spi_addr == `RXTC_ADR_REFOSC) begin
			refosc_reg <= spi_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			synthbw_reg <= `RXTC_RST_SYNTHBW;
		end else if (spi_wr && spi_addr == `RXTC_ADR_SYNTHBW) begin
			synthbw_reg <= spi_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			fading_reg <= `RXTC_RST_FADING;
		end else if (spi_wr && spi_addr == `RXTC_ADR_FADING) begin
			fading_reg <= spi_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			offset_reg <= `RXTC_RST_OFFSET;
		end else if (spi_wr && spi_addr == `RXTC_ADR_OFFSET) begin
			offset_reg <= spi_wdata;
		end
	end

	// Unmapped addresses read zero
	always_comb begin
		case (spi_addr)
			`RXTC_ADR_LNA: spi_rdata = lna_reg;
			`RXTC_ADR_REFOSC: spi_rdata = refosc_reg;
			`RXTC_ADR_SYNTHBW: spi_rdata = synthbw_reg;
			`RXTC_ADR_FADING: spi_rdata = fading_reg;
			`RXTC_ADR_OFFSET: spi_rdata = offset_reg;
			default: spi_rdata = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Tuning outputs
	// ----------------------------------------
	// Registered one cycle behind the bank to keep outputs glitch-free
	always_ff @(posedge mclk) begin
		if (rst) begin
			lna_gain_select <= `RXTC_RST_LNA;
			high_sens_mode <= 1'b0;
			ext_ref_select <= RST_REF[`RXTC_EXT_REF_BIT];
			synth_loop_bw <= RST_BW[`RXTC_BW_MSB:`RXTC_BW_LSB];
			synth_bw_khz <= bw_khz(RST_BW[`RXTC_BW_MSB:`RXTC_BW_LSB]);
			fading_margin_setting <= `RXTC_RST_FADING;
			fading_mode <= RXTC_FADE_AFC_OFF;
			narrow_index_freq_offset <= `RXTC_RST_OFFSET;
			freq_offset_hz <= 17'h00000;
		end else begin
			lna_gain_select <= lna_reg;
			high_sens_mode <= (lna_reg == `RXTC_LNA_HIGH);
			ext_ref_select <= refosc_reg[`RXTC_EXT_REF_BIT];
			synth_loop_bw <= synthbw_reg[`RXTC_BW_MSB:`RXTC_BW_LSB];
			synth_bw_khz <= bw_khz(synthbw_reg[`RXTC_BW_MSB:`RXTC_BW_LSB]);
			fading_margin_setting <= fading_reg;
			fading_mode <= fade_decode(fading_reg);
			narrow_index_freq_offset <= offset_reg;
			if (narrow_index_afc_enable) begin
				freq_offset_hz <= 17'(offset_reg * `RXTC_OFS_STEP_HZ);
			end else begin
				freq_offset_hz <= 17'h00000;
			end
		end
	end
endmodule : rxtc_device

//--- rxtc_host.sv
// Purpose: Host end: APB registers drive SPI frames and reset pin
// Assumes: Device answers SPI only after its boot
// Notes: Waits may end early on aux clock activity when enabled
`timescale 1ns/100ps
`include "rxtc_defines.svh"
module rxtc_host import rxtc_pkg::*; #(
	parameter logic [19:0] POR_WAIT_CYC = 20'(`RXTC_POR_WAIT_CYC),
	parameter logic [19:0] MRST_PULSE_CYC = 20'(`RXTC_MRST_PULSE_CYC),
	parameter logic [19:0] MRST_WAIT_CYC = 20'(`RXTC_MRST_WAIT_CYC)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to device
	rxtc_link_if.host link
);
	rxtc_hstate_t state_reg;
	logic [19:0] wait_reg;
	logic [2:0] div_reg;
	logic [3:0] nbit_reg;
	logic [15:0] tx_reg, rx_reg;
	logic [7:0] rdata_reg, wdata_reg;
	logic [6:0] addr_reg;
	logic wr_reg, auxrdy_reg;
	logic miso_s1_reg, miso_s2_reg, aux_s1_reg, aux_s2_reg, aux_s3_reg;
	logic apb_wr, go, mrst, aux_seen;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr = psel && penable && pwrite;
	assign go = apb_wr && paddr == `RXTC_APB_CTRL && pwdata[`RXTC_CTRL_GO];
	assign mrst = apb_wr && paddr == `RXTC_APB_CTRL && pwdata[`RXTC_CTRL_MRST];

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		miso_s1_reg <= link.miso;
		miso_s2_reg <= miso_s1_reg;
		aux_s1_reg <= link.aux_clock_out;
		aux_s2_reg <= aux_s1_reg;
		aux_s3_reg <= aux_s2_reg;
	end

	assign aux_seen = auxrdy_reg && (aux_s2_reg ^ aux_s3_reg);

	// ----------------------------------------
	// APB registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			auxrdy_reg <= 1'b0;
			wr_reg <= 1'b0;
			addr_reg <= 7'h00;
			wdata_reg <= 8'h00;
		end else if (apb_wr && paddr == `RXTC_APB_CTRL) begin
			auxrdy_reg <= pwdata[`RXTC_CTRL_AUXRDY];
			wr_reg <= pwdata[`RXTC_CTRL_WR];
		end else if (apb_wr && paddr == `RXTC_APB_XFER) begin
			addr_reg <= pwdata[14:8];
			wdata_reg <= pwdata[7:0];
		end
	end

	always_comb begin
		case (paddr)
			`RXTC_APB_CTRL: prdata = {28'h0000000, auxrdy_reg, 1'b0, wr_reg, 1'b0};
			`RXTC_APB_XFER: prdata = {17'h00000, addr_reg, wdata_reg};
			`RXTC_APB_STAT: prdata = {16'h0000, rdata_reg, 6'h00,
				state_reg == RXTC_H_IDLE, state_reg != RXTC_H_IDLE};
			default: prdata = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// Sequencer and SPI master
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= RXTC_H_POR;
			wait_reg <= 20'h00000;
			div_reg <= 3'h0;
			nbit_reg <= 4'h0;
			tx_reg <= 16'h0000;
			rx_reg <= 16'h0000;
			rdata_reg <= 8'h00;
			link.sck <= 1'b0;
			link.cs_n <= 1'b1;
			link.mosi <= 1'b0;
			link.rst_pin_o <= 1'b0;
			link.rst_pin_oe_n <= 1'b1;
		end else begin
			case (state_reg)
				RXTC_H_POR: begin
					wait_reg <= wait_reg + 20'h00001;
					if (wait_reg == POR_WAIT_CYC - 20'h00001 || aux_seen) begin
						state_reg <= RXTC_H_IDLE;
					end
				end
				RXTC_H_IDLE: begin
					wait_reg <= 20'h00000;
					div_reg <= 3'h0;
					nbit_reg <= 4'h0;
					if (mrst) begin
						state_reg <= RXTC_H_MRST;
						link.rst_pin_o <= 1'b1;
						link.rst_pin_oe_n <= 1'b0;
					end else if (go) begin
						state_reg <= RXTC_H_XFER;
						tx_reg <= {pwdata[`RXTC_CTRL_WR], addr_reg, wdata_reg};
						link.mosi <= pwdata[`RXTC_CTRL_WR];
						link.cs_n <= 1'b0;
					end
				end
				RXTC_H_XFER: begin
					div_reg <= div_reg + 3'h1;
					if (div_reg == `RXTC_SCK_HALF) begin
						link.sck <= !link.sck;
						if (link.sck) begin
							rx_reg <= {rx_reg[14:0], miso_s2_reg};
							nbit_reg <= nbit_reg + 4'h1;
							tx_reg <= {tx_reg[14:0], 1'b0};
							link.mosi <= tx_reg[14];
							if (nbit_reg == `RXTC_SPI_LAST) begin
								rdata_reg <= {rx_reg[6:0], miso_s2_reg};
								link.cs_n <= 1'b1;
								state_reg <= RXTC_H_IDLE;
							end
						end
					end
				end
				RXTC_H_MRST: begin
					wait_reg <= wait_reg + 20'h00001;
					if (wait_reg == MRST_PULSE_CYC - 20'h00001) begin
						wait_reg <= 20'h00000;
						link.rst_pin_o <= 1'b0;
						link.rst_pin_oe_n <= 1'b1;
						state_reg <= RXTC_H_MWAIT;
					end
				end
				RXTC_H_MWAIT: begin
					wait_reg <= wait_reg + 20'h00001;
					if (wait_reg == MRST_WAIT_CYC - 20'h00001 || aux_seen) begin
						state_reg <= RXTC_H_IDLE;
					end
				end
				default: begin
					state_reg <= RXTC_H_POR;
				end
			endcase
		end
	end
endmodule : rxtc_host

//--- rxtc_link_if.sv
// Purpose: Pins between host and receiver: SPI, reset pin, aux clock
// Assumes: Undriven lines read low, as through a pull-down
// Notes: Output enables are active low
`timescale 1ns/100ps
interface rxtc_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe_n;
	logic miso;
	logic rst_pin_o;
	logic rst_pin_oe_n;
	logic rst_pin;
	logic aux_clock_out;

	assign miso = !miso_oe_n & miso_o;
	assign rst_pin = !rst_pin_oe_n & rst_pin_o;

	modport device (
		input sck, cs_n, mosi, rst_pin,
		output miso_o, miso_oe_n, aux_clock_out
	);
	modport host (
		output sck, cs_n, mosi, rst_pin_o, rst_pin_oe_n,
		input miso, aux_clock_out
	);
endinterface : rxtc_link_if

//--- rxtc_link_monitor.sv
// Purpose: Checker on the link between host and receiver ends
// Assumes: One clock domain, rst synchronous active high
// Notes: Sees interface signals only, instantiated beside the link
`timescale 1ns/100ps
module rxtc_link_monitor #(
	parameter int POR_WAIT_CYC = 2000,
	parameter int MRST_PULSE_CYC = 20,
	parameter int MRST_WAIT_CYC = 2000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic miso_oe_n,
	input wire logic rst_pin_oe_n,
	input wire logic rst_pin,
	input wire logic aux_clock_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [19:0] wait_cnt;
	logic [19:0] hi_cnt;
	logic [4:0] bit_cnt;
	logic pin_mode;
	logic aux_seen;

	// Quiet time since power-on or pin release
	always_ff @(posedge mclk) begin
		if (rst || rst_pin)
			wait_cnt <= 20'h00000;
		else if (wait_cnt != 20'hFFFFF)
			wait_cnt <= wait_cnt + 20'h00001;
	end
	always_ff @(posedge mclk) begin
		if (rst_pin)
			hi_cnt <= hi_cnt + 20'h00001;
		else
			hi_cnt <= 20'h00000;
	end
	always_ff @(posedge mclk) begin
		if (cs_n)
			bit_cnt <= 5'h00;
		else if ($rose(sck))
			bit_cnt <= bit_cnt + 5'h01;
	end
	always_ff @(posedge mclk) begin
		if (rst)
			pin_mode <= 1'b0;
		else if (rst_pin)
			pin_mode <= 1'b1;
	end
	// Device holds aux low until booted, so any high level is activity
	always_ff @(posedge mclk) begin
		if (rst || rst_pin)
			aux_seen <= 1'b0;
		else if (aux_clock_out)
			aux_seen <= 1'b1;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_pin_float_por: assert property (!pin_mode && wait_cnt < POR_WAIT_CYC |-> rst_pin_oe_n)
		else $error("reset pin driven right after power-on");
	a_pulse_width: assert property ($fell(rst_pin) |-> hi_cnt == MRST_PULSE_CYC)
		else $error("manual reset pulse length wrong");
	a_no_frame_pin: assert property (!rst_pin_oe_n |-> cs_n)
		else $error("frame started while reset pin driven");
	a_por_quiet: assert property ($fell(cs_n) && !pin_mode |->
		aux_seen || wait_cnt >= POR_WAIT_CYC - 2)
		else $error("frame too soon after power-on");
	a_mrst_quiet: assert property ($fell(cs_n) && pin_mode |->
		aux_seen || wait_cnt >= MRST_WAIT_CYC - 2)
		else $error("frame too soon after manual reset");
	a_frame_bits: assert property ($rose(cs_n) |-> bit_cnt == 5'h10)
		else $error("frame not sixteen clocks");
	a_miso_release: assert property (cs_n [*3] |-> miso_oe_n)
		else $error("data line driven while not selected");
	a_aux_hold: assert property (rst_pin [*6] |-> !aux_clock_out)
		else $error("aux clock runs during manual reset");
	a_aux_period: assert property (disable iff (rst || rst_pin)
		$rose(aux_clock_out) |=> aux_clock_out [*3] ##1 !aux_clock_out)
		else $error("aux clock period wrong");
endmodule : rxtc_link_monitor

//--- rxtc_pkg.sv
// Purpose: Types of the receiver tuning bank and its host
// Assumes: Nothing
// Notes: Constants live in rxtc_defines.svh
package rxtc_pkg;
	typedef enum logic [1:0] {
		RXTC_FADE_NORMAL = 2'b00,
		RXTC_FADE_AFC_ON = 2'b01,
		RXTC_FADE_AFC_OFF = 2'b10,
		RXTC_FADE_OTHER = 2'b11
	} rxtc_fade_t;
	typedef enum logic [1:0] {
		RXTC_D_HOLD = 2'b00,
		RXTC_D_BOOT = 2'b01,
		RXTC_D_READY = 2'b10
	} rxtc_dstate_t;
	typedef enum logic [2:0] {
		RXTC_H_POR = 3'b000,
		RXTC_H_IDLE = 3'b001,
		RXTC_H_XFER = 3'b010,
		RXTC_H_MRST = 3'b011,
		RXTC_H_MWAIT = 3'b100
	} rxtc_hstate_t;
endpackage : rxtc_pkg

//--- rxtc_spi_slave.sv
// Purpose: Oversampled SPI mode 0 slave, 16-bit frames
// Assumes: Frame is R/W bit, 7 address bits, 8 data bits, MSB first
// Notes: Read data leaves on falling sck edges after the address byte
`timescale 1ns/100ps
`include "rxtc_defines.svh"
module rxtc_spi_slave import rxtc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Pins
	input wire logic sck_pin,
	input wire logic cs_n_pin,
	input wire logic mosi_pin,
	output logic miso_o,
	output logic miso_oe_n,
	// Register side
	input wire logic [7:0] rdata,
	output logic [6:0] addr,
	output logic [7:0] wdata,
	output logic wr_pulse
);
	logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
	logic cs_s1_reg, cs_s2_reg, mosi_s1_reg, mosi_s2_reg;
	logic [3:0] cnt_reg;
	logic [6:0] shin_reg;
	logic [7:0] shout_reg;
	logic is_wr_reg, load_reg;
	logic rise, fall;

	always_ff @(posedge mclk) begin
		sck_s1_reg <= sck_pin;
		sck_s2_reg <= sck_s1_reg;
		sck_s3_reg <= sck_s2_reg;
		cs_s1_reg <= cs_n_pin;
		cs_s2_reg <= cs_s1_reg;
		mosi_s1_reg <= mosi_pin;
		mosi_s2_reg <= mosi_s1_reg;
	end

	assign rise = sck_s2_reg & !sck_s3_reg;
	assign fall = !sck_s2_reg & sck_s3_reg;
	assign miso_oe_n = cs_s2_reg;

	always_ff @(posedge mclk) begin
		if (rst || cs_s2_reg) begin
			cnt_reg <= 4'h0;
			is_wr_reg <= 1'b0;
			addr <= 7'h00;
			wr_pulse <= 1'b0;
			load_reg <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			load_reg <= 1'b0;
			if (rise) begin
				cnt_reg <= cnt_reg + 4'h1;
				shin_reg <= {shin_reg[5:0], mosi_s2_reg};
				if (cnt_reg == `RXTC_ADDR_LAST) begin
					addr <= {shin_reg[5:0], mosi_s2_reg};
					is_wr_reg <= shin_reg[6];
					load_reg <= 1'b1;
				end
				if (cnt_reg == `RXTC_SPI_LAST && is_wr_reg) begin
					wdata <= {shin_reg, mosi_s2_reg};
					wr_pulse <= 1'b1;
				end
			end
		end
	end

	// Address is one cycle old when loaded, long before the next fall
	always_ff @(posedge mclk) begin
		if (rst) begin
			shout_reg <= 8'h00;
			miso_o <= 1'b0;
		end else if (load_reg) begin
			shout_reg <= rdata;
		end else if (fall) begin
			miso_o <= shout_reg[7];
			shout_reg <= {shout_reg[6:0], 1'b0};
		end
	end
endmodule : rxtc_spi_slave
